// ===== design/pss_regs_top.sv
/*
 * register slice: pwm2 duty, pwm period select, host scratch byte and
 * supply fail status b, reached over the 16-bit serial link.
 * assumes soft_reset, restart_entry and normal_mode come from mode logic
 * on clk_sys; supply detector levels arrive asynchronously.
 */
// How it works
// R1: duty zero is always off, all ones always on, else on for value/255 of the period.
// R2: period select bit 2 steers channel two and bit 0 channel one, clear 200 hz, set 400 hz.
// R3: reserved bit positions always read back as zero.
// R4: restart keeps both period select bits and zeroes the rest; resets clear it all.
// R5: duty byte of channel two lives at its own offset, clears on resets, survives restart.
// R6: the scratch byte clears only at power-on and survives a soft reset.
// R7: nothing internal changes the scratch byte, not restart nor fail-safe.
// R8: a frame is 16 bits: seven address bits, one access mode bit, then a data byte.
// R9: data bits zero to seven ride in frame positions eight to fifteen.
// R10: mode bit zero reads a status register and leaves it alone.
// R11: mode bit one clears the clearable status bits of the byte, others untouched.
// R12: status flags stay latched until the host clears them by frame.
// R13: main supply undervoltage sets and latches bit 6, host may clear it.
// R14: primary rail overvoltage sets and latches bit 1, host may clear it.
// R15: primary rail prewarning sets and latches bit 0 from its own fixed threshold.
// R16: restart keeps status bits 6, 1 and 0 and zeroes the rest; resets clear it all.
// R17: each pwm compares a free 255-step counter, paced by the chosen period, to the duty.
`timescale 1ns/1ns
module pss_regs_top (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    input wire logic soft_reset,
    input wire logic restart_entry,
    input wire logic normal_mode,
    input wire logic main_supply_low_det,
    input wire logic primary_rail_high_det,
    input wire logic primary_rail_prewarn_det,
    input wire logic [7:0] channel_one_duty_value,
    output logic pwm_channel_one_out,
    output logic pwm_channel_two_out
);
    pss_frame_if fif ();

    // ---- cross-domain and pin synchronisers
    logic [2:0] det_meta_r, det_meta_nxt;
    logic [2:0] det_sync_r, det_sync_nxt;
    logic tgl_meta_r, tgl_meta_nxt;
    logic tgl_sync_r, tgl_sync_nxt;
    logic tgl_seen_r, tgl_seen_nxt;
    logic frame_evt;

    // ---- command handling
    pss_pkg::pss_cmd_st_t state_r, state_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [15:0] reply_r, reply_nxt;
    logic [6:0] cmd_addr;
    logic cmd_mode;
    logic [7:0] cmd_data;
    logic do_exec;
    logic wr_duty;
    logic wr_freq;
    logic wr_scratch;
    logic clr_sup;
    logic [7:0] rd_data;

    // ---- registers
    logic [7:0] duty2_r, duty2_nxt;
    logic [7:0] freq_r, freq_nxt;
    logic [7:0] scratch_r, scratch_nxt;
    logic [7:0] sup_r, sup_nxt;
    logic [7:0] sup_set;
    logic [7:0] sup_base;

    function automatic logic [7:0] keep_bits(input logic [7:0] value, input logic [7:0] mask);
        keep_bits = value & mask;
    endfunction : keep_bits

    function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] target);
        addr_is = (addr == target);
    endfunction : addr_is

    // ---- synchroniser stage logic
    always_comb begin
        det_meta_nxt = {main_supply_low_det, primary_rail_high_det, primary_rail_prewarn_det};
        det_sync_nxt = det_meta_r;
        tgl_meta_nxt = fif.frame_tgl;
        tgl_sync_nxt = tgl_meta_r;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            det_meta_r <= 3'h0;
            det_sync_r <= 3'h0;
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
        end else if (ce) begin
            det_meta_r <= det_meta_nxt;
            det_sync_r <= det_sync_nxt;
            tgl_meta_r <= tgl_meta_nxt;
            tgl_sync_r <= tgl_sync_nxt;
        end
    end

    assign frame_evt = tgl_sync_r ^ tgl_seen_r;

    // ---- frame decode
    assign cmd_addr = cmd_r[pss_pkg::ADDR_W-1:0]; // R8
    assign cmd_mode = cmd_r[pss_pkg::MODE_BIT]; // R8 R10 R11
    assign cmd_data = cmd_r[pss_pkg::FRAME_W-1:pss_pkg::DATA_LSB]; // R9
    assign do_exec = (state_r == pss_pkg::PSS_ST_EXEC);

    always_comb begin
        wr_duty = do_exec & cmd_mode & addr_is(cmd_addr, pss_pkg::ADDR_PWM2_DUTY); // R5
        wr_freq = do_exec & cmd_mode & addr_is(cmd_addr, pss_pkg::ADDR_FREQ_SEL);
        wr_scratch = do_exec & cmd_mode & normal_mode
                     & addr_is(cmd_addr, pss_pkg::ADDR_SCRATCH);
        clr_sup = do_exec & cmd_mode & addr_is(cmd_addr, pss_pkg::ADDR_SUP_STAT_B); // R11
    end

    // ---- read mux, old value returned, unmapped reads zero
    always_comb begin
        rd_data = 8'h00;
        if (addr_is(cmd_addr, pss_pkg::ADDR_PWM2_DUTY)) begin
            rd_data = duty2_r;
        end else if (addr_is(cmd_addr, pss_pkg::ADDR_FREQ_SEL)) begin
            rd_data = keep_bits(freq_r, pss_pkg::FREQ_SEL_MASK); // R3
        end else if (addr_is(cmd_addr, pss_pkg::ADDR_SCRATCH)) begin
            rd_data = scratch_r;
        end else if (addr_is(cmd_addr, pss_pkg::ADDR_SUP_STAT_B)) begin
            rd_data = keep_bits(sup_r, pss_pkg::SUP_STAT_B_MASK); // R3 R10
        end
    end

    // ---- command state machine
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        reply_nxt = reply_r;
        tgl_seen_nxt = tgl_seen_r;
        case (state_r)
            pss_pkg::PSS_ST_IDLE: begin
                if (frame_evt) begin
                    cmd_nxt = fif.frame_word;
                    tgl_seen_nxt = tgl_sync_r;
                    state_nxt = pss_pkg::PSS_ST_EXEC;
                end
            end
            pss_pkg::PSS_ST_EXEC: begin
                reply_nxt = {rd_data, cmd_addr, 1'b0}; // R9 R10
                state_nxt = pss_pkg::PSS_ST_IDLE;
            end
            default: begin
                state_nxt = pss_pkg::PSS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= pss_pkg::PSS_ST_IDLE;
            cmd_r <= 16'h0000;
            reply_r <= 16'h0000;
            tgl_seen_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            reply_r <= reply_nxt;
            tgl_seen_r <= tgl_seen_nxt;
        end
    end

    assign fif.reply_word = reply_r;

    // ---- channel two duty byte
    always_comb begin
        duty2_nxt = duty2_r; // R5
        if (soft_reset) begin
            duty2_nxt = pss_pkg::RST_PWM2_DUTY; // R5
        end else if (wr_duty) begin
            duty2_nxt = cmd_data; // R5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            duty2_r <= pss_pkg::RST_PWM2_DUTY;
        end else if (ce) begin
            duty2_r <= duty2_nxt;
        end
    end

    // ---- period select register
    always_comb begin
        freq_nxt = freq_r;
        if (soft_reset) begin
            freq_nxt = pss_pkg::RST_FREQ_SEL; // R4
        end else if (restart_entry) begin
            freq_nxt = keep_bits(freq_r, pss_pkg::FREQ_SEL_MASK); // R4
        end else if (wr_freq) begin
            freq_nxt = keep_bits(cmd_data, pss_pkg::FREQ_SEL_MASK); // R3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_r <= pss_pkg::RST_FREQ_SEL;
        end else if (ce) begin
            freq_r <= freq_nxt;
        end
    end

    // ---- host scratch byte, only power-on clears it
    always_comb begin
        scratch_nxt = scratch_r; // R6 R7
        if (wr_scratch) begin
            scratch_nxt = cmd_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scratch_r <= pss_pkg::RST_SCRATCH; // R6
        end else if (ce) begin
            scratch_r <= scratch_nxt;
        end
    end

    // ---- supply fail status b, set beats clear
    always_comb begin
        sup_set = 8'h00;
        sup_set[pss_pkg::MAIN_LOW_BIT] = det_sync_r[2]; // R13
        sup_set[pss_pkg::PRIMARY_HIGH_BIT] = det_sync_r[1]; // R14
        sup_set[pss_pkg::PRIMARY_PREWARN_BIT] = det_sync_r[0]; // R15
        sup_base = sup_r; // R12
        if (restart_entry) begin
            sup_base = keep_bits(sup_r, pss_pkg::SUP_STAT_B_MASK); // R16
        end else if (clr_sup) begin
            sup_base = sup_r & ~pss_pkg::SUP_STAT_B_MASK; // R11
        end
        if (soft_reset) begin
            sup_nxt = pss_pkg::RST_SUP_STAT_B; // R16
        end else begin
            sup_nxt = keep_bits(sup_base | sup_set, pss_pkg::SUP_STAT_B_MASK); // R12 R3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sup_r <= pss_pkg::RST_SUP_STAT_B;
        end else if (ce) begin
            sup_r <= sup_nxt;
        end
    end

    // ---- link and pwm channels
    pss_spi_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .link_rst(srst),
        .mosi(mosi),
        .miso(miso),
        .fif(fif.link)
    );

    pss_pwm_gen u_pwm1 (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .duty(channel_one_duty_value),
        .fast_sel(freq_r[pss_pkg::CH1_PERIOD_BIT]), // R2
        .pwm_out(pwm_channel_one_out)
    );

    pss_pwm_gen u_pwm2 (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .duty(duty2_r),
        .fast_sel(freq_r[pss_pkg::CH2_PERIOD_BIT]), // R2
        .pwm_out(pwm_channel_two_out)
    );
endmodule : pss_regs_top

// ===== inc/pss_pkg.sv
/*
 * shared constants of the supply status and pwm register slice.
 * assumes a 125 mhz system clock and lsb-first 16-bit serial frames.
 */
package pss_pkg;
    localparam int ADDR_W = 7;
    localparam int FRAME_W = 16;
    localparam int MODE_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int CNT_W = 4;
    localparam logic [3:0] LAST_BIT = 4'hf;
    // register offsets
    localparam logic [6:0] ADDR_PWM2_DUTY = 7'h19;
    localparam logic [6:0] ADDR_FREQ_SEL = 7'h1c;
    localparam logic [6:0] ADDR_SCRATCH = 7'h1e;
    localparam logic [6:0] ADDR_SUP_STAT_B = 7'h40;
    // values after power-on and soft reset; scratch takes its value after power-on only
    localparam logic [7:0] RST_PWM2_DUTY = 8'h00;
    localparam logic [7:0] RST_FREQ_SEL = 8'h00;
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [7:0] RST_SUP_STAT_B = 8'h00;
    // field positions
    localparam int CH1_PERIOD_BIT = 0;
    localparam int CH2_PERIOD_BIT = 2;
    localparam logic [7:0] FREQ_SEL_MASK = 8'h05;
    localparam int PRIMARY_PREWARN_BIT = 0;
    localparam int PRIMARY_HIGH_BIT = 1;
    localparam int MAIN_LOW_BIT = 6;
    localparam logic [7:0] SUP_STAT_B_MASK = 8'h43;
    // duty encodings
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    // pwm timing
    localparam int CLK_FREQ_HZ = 125000000;
    localparam int PWM_SLOW_HZ = 200;
    localparam int PWM_FAST_HZ = 400;
    localparam int PWM_STEPS = 255;
    localparam logic [7:0] LAST_STEP = 8'(PWM_STEPS - 1);
    localparam logic [11:0] STEP_CYC_SLOW = 12'(CLK_FREQ_HZ / (PWM_SLOW_HZ * PWM_STEPS));
    localparam logic [11:0] STEP_CYC_FAST = 12'(CLK_FREQ_HZ / (PWM_FAST_HZ * PWM_STEPS));

    typedef enum logic [1:0] {
        PSS_ST_IDLE = 2'b00,
        PSS_ST_EXEC = 2'b01
    } pss_cmd_st_t;
endpackage : pss_pkg

// ===== inc/pss_frame_if.sv
/*
 * frame hand-over between the serial link and the register core.
 * assumes frame_word is stable whenever frame_tgl has settled.
 */
`timescale 1ns/1ns
interface pss_frame_if;
    logic [15:0] frame_word;
    logic frame_tgl;
    logic [15:0] reply_word;
    modport link (output frame_word, output frame_tgl, input reply_word);
    modport core (input frame_word, input frame_tgl, output reply_word);
endinterface : pss_frame_if

// ===== design/pss_spi_link.sv
/*
 * serial slave on the link clock: shifts 16-bit frames lsb first.
 * assumes sclk only moves while cs_n is low, mosi sampled on rising edge.
 */
`timescale 1ns/1ns
module pss_spi_link (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic link_rst,
    input wire logic mosi,
    output logic miso,
    pss_frame_if.link fif
);
    logic [3:0] cnt_r, cnt_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic [15:0] tx_r, tx_nxt;
    logic [15:0] word_r, word_nxt;
    logic tgl_r, tgl_nxt;

    always_comb begin
        cnt_nxt = 4'(cnt_r + 4'h1);
        rx_nxt = {mosi, rx_r[15:1]}; // R8 R9
        tx_nxt = (cnt_r == 4'h0) ? {1'b0, fif.reply_word[15:1]} : {1'b0, tx_r[15:1]};
        word_nxt = word_r;
        tgl_nxt = tgl_r;
        if (cnt_r == pss_pkg::LAST_BIT) begin // R8
            word_nxt = {mosi, rx_r[15:1]};
            tgl_nxt = ~tgl_r;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_r <= 4'h0;
            rx_r <= 16'h0000;
            tx_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
        end
    end

    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            word_r <= 16'h0000;
            tgl_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            tgl_r <= tgl_nxt;
        end
    end

    assign miso = tx_r[0];
    assign fif.frame_word = word_r;
    assign fif.frame_tgl = tgl_r;
endmodule : pss_spi_link

// ===== design/pss_pwm_gen.sv
/*
 * one pwm channel: 255-step period counter against a duty byte.
 * assumes duty and period select come from registers on clk_sys.
 */
`timescale 1ns/1ns
module pss_pwm_gen (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] duty,
    input wire logic fast_sel,
    output logic pwm_out
);
    logic [11:0] presc_r, presc_nxt;
    logic [7:0] step_r, step_nxt;
    logic out_r, out_nxt;
    logic [11:0] limit;

    always_comb begin
        limit = fast_sel ? 12'(pss_pkg::STEP_CYC_FAST - 12'h001)
                         : 12'(pss_pkg::STEP_CYC_SLOW - 12'h001); // R2 R17
        presc_nxt = 12'(presc_r + 12'h001);
        step_nxt = step_r;
        if (presc_r >= limit) begin
            presc_nxt = 12'h000;
            step_nxt = (step_r >= pss_pkg::LAST_STEP) ? 8'h00 : 8'(step_r + 8'h01); // R17
        end
        if (duty == pss_pkg::DUTY_FULL) begin // R1
            out_nxt = 1'b1;
        end else if (duty == pss_pkg::DUTY_OFF) begin // R1
            out_nxt = 1'b0;
        end else begin
            out_nxt = (step_r < duty); // R1 R17
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            presc_r <= 12'h000;
            step_r <= 8'h00;
            out_r <= 1'b0;
        end else if (ce) begin
            presc_r <= presc_nxt;
            step_r <= step_nxt;
            out_r <= out_nxt;
        end
    end

    assign pwm_out = out_r;
endmodule : pss_pwm_gen

// ===== dv/pss_host_model.sv
/*
 * host side serial master model: 16-bit frames, lsb first, 6 ns link clock.
 * assumes the reply of one frame is shifted out during the next one.
 */
`timescale 1ns/1ns
module pss_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // link clock stands still between frames
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n = 1'b0;
        #3;
        r[0] = miso;
        for (int k = 0; k < 16; k++) begin
            mosi = w[k];
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
            if (k < 15) begin
                r[k+1] = miso;
            end
        end
        #3 cs_n = 1'b1;
        mosi = ~mosi;
        #100;
    endtask : xfer
endmodule : pss_host_model

// ===== dv/pss_regs_top_props.sv
/*
 * port level assertions of the register slice.
 * assumes binding onto pss_regs_top with ce held high.
 */
`timescale 1ns/1ns
module pss_regs_top_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic miso,
    input wire logic soft_reset,
    input wire logic [7:0] channel_one_duty_value,
    input wire logic pwm_channel_one_out,
    input wire logic pwm_channel_two_out
);
    logic [1:0] rh_r;
    logic [11:0] hi_r;
    wire [7:0] d1 = channel_one_duty_value;
    wire p1 = pwm_channel_one_out;
    wire settled = rh_r == 2'b00;

    // reset history and length of the current high run
    always_ff @(posedge clk_sys) begin
        rh_r <= {rh_r[0], srst};
        hi_r <= (srst || !p1) ? 12'h000 : hi_r + 12'h001;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    AST_OFF_ONE: assert property (
        d1 == 8'h00 && $past(d1) == 8'h00 |-> !p1) else $error("pwm one high at zero duty");
    AST_FULL_ONE: assert property (
        settled && d1 == 8'hff && $past(d1) == 8'hff |-> p1) else $error("pwm one low at full duty");
    AST_ROSE_ONE: assert property (
        $rose(p1) |-> $past(d1) != 8'h00 || $past(d1, 2) != 8'h00)
        else $error("pwm one rose at zero duty");
    AST_FELL_ONE: assert property (
        settled && $fell(p1) |-> $past(d1) != 8'hff || $past(d1, 2) != 8'hff)
        else $error("pwm one fell at full duty");
    AST_STEP_ONE: assert property (
        d1 == 8'h01 |-> hi_r <= 12'h994) else $error("pwm one step too long");
    AST_IDLE_MISO: assert property (
        cs_n && $past(cs_n) |-> !miso) else $error("miso driven outside frame");
    AST_SOFT_TWO: assert property (
        soft_reset |-> ##3 !pwm_channel_two_out) else $error("pwm two on after soft reset");
    AST_REL_OUT: assert property (
        $fell(srst) |-> !p1 && !pwm_channel_two_out) else $error("pwm on after reset");
endmodule : pss_regs_top_props

bind pss_regs_top pss_regs_top_props u_props (
    .clk_sys, .srst, .cs_n, .miso, .soft_reset, .channel_one_duty_value,
    .pwm_channel_one_out, .pwm_channel_two_out
);

// ===== dv/tb_top.sv
/*
 * self-checking bench of the register slice: frames, status, pwm.
 * assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module tb_top;
    logic clk_sys, srst, ce, sclk, cs_n, mosi, miso;
    logic soft_reset, restart_entry, normal_mode, pwm1, pwm2, cnt_en;
    logic [2:0] det;
    logic [7:0] duty1;
    logic [7:0] sb [3] = '{8'h01, 8'h02, 8'h40};
    logic [15:0] rsp;
    int bad_count, tests_run, h1, h2, cyc;

    pss_regs_top uut (.clk_sys, .srst, .ce, .sclk, .cs_n, .mosi, .miso, .soft_reset,
        .restart_entry, .normal_mode, .main_supply_low_det(det[2]),
        .primary_rail_high_det(det[1]), .primary_rail_prewarn_det(det[0]),
        .channel_one_duty_value(duty1), .pwm_channel_one_out(pwm1),
        .pwm_channel_two_out(pwm2));
    pss_host_model host (.sclk, .cs_n, .mosi, .miso);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // high-cycle counters and hang limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cnt_en) begin
            h1 += int'(pwm1);
            h2 += int'(pwm2);
        end
        if (cyc == 30000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({d, 1'b1, a}, rsp);
    endtask : wr

    // read frame, then a dummy frame that carries its reply
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer({8'hff, 1'b0, a}, rsp);
        host.xfer({8'hff, 1'b0, 7'h7f}, rsp);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rsp[15:8]});
    endtask : rd

    // expected bytes: {status, scratch, period select, duty two}
    task automatic chk_all(input logic [31:0] e);
        logic [6:0] adr [4];
        adr = '{7'h19, 7'h1c, 7'h1e, 7'h40};
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], e[8*i+:8]);
        end
    endtask : chk_all

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : pulse

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        soft_reset = 1'b0;
        restart_entry = 1'b0;
        normal_mode = 1'b1;
        det = 3'h0;
        duty1 = 8'h01;
        cnt_en = 1'b0;
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        cnt_en = 1'b1;
        @(negedge clk_sys);
        wr(7'h1c, 8'h04);
        wr(7'h19, 8'h01);
        repeat (2900) @(negedge clk_sys);
        cnt_en = 1'b0;
        chk("pwm one slow step", 16'h0001, 16'(h1 >= 2448 && h1 <= 2452));
        chk("pwm two fast step", 16'h0001, 16'(h2 >= 1100 && h2 <= 1226));
        $display("test pwm step done");
        pulse(srst);
        chk_all(32'h00000000);
        wr(7'h19, 8'h5a);
        wr(7'h1c, 8'hff);
        wr(7'h1e, 8'ha5);
        wr(7'h20, 8'hff);
        chk_all(32'h00a5055a);
        rd(7'h20, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            det[i] = 1'b1;
            repeat (4) @(negedge clk_sys);
            det[i] = 1'b0;
            repeat (4) @(negedge clk_sys);
            rd(7'h40, sb[i]);
            rd(7'h40, sb[i]);
            wr(7'h40, 8'hff);
            rd(7'h40, 8'h00);
        end
        $display("test status done");
        @(negedge clk_sys);
        det = 3'h7;
        repeat (4) @(negedge clk_sys);
        det = 3'h0;
        repeat (4) @(negedge clk_sys);
        pulse(restart_entry);
        chk_all(32'h43a5055a);
        pulse(soft_reset);
        chk_all(32'h00a50000);
        @(negedge clk_sys);
        normal_mode = 1'b0;
        wr(7'h1e, 8'h3c);
        rd(7'h1e, 8'ha5);
        @(negedge clk_sys);
        normal_mode = 1'b1;
        pulse(srst);
        rd(7'h1e, 8'h00);
        $display("test restart and resets done");
        for (int v = 0; v < 2; v++) begin
            @(negedge clk_sys);
            duty1 = v ? 8'hff : 8'h00;
            wr(7'h19, duty1);
            repeat (4) @(negedge clk_sys);
            h1 = 0;
            h2 = 0;
            cnt_en = 1'b1;
            repeat (3000) @(negedge clk_sys);
            cnt_en = 1'b0;
            chk("pwm one level", v ? 16'h0bb8 : 16'h0000, 16'(h1));
            chk("pwm two level", v ? 16'h0bb8 : 16'h0000, 16'(h2));
        end
        $display("test pwm levels done");
        complete_run();
    end
endmodule : tb_top
